// ---- i2c_master_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  // clock and resolved data line
  input wire logic ref_clk,
  input wire logic sda_bus,
  // drives, high means released
  output var logic scl,
  output var logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // data moves only mid-low, so it is steady while scl is high
  task automatic bit_io(input logic b, output logic r);
    hold(6);
    sda_drv <= b;
    hold(6);
    scl <= 1'b1;
    hold(12);
    r = sda_bus;
    scl <= 1'b0;
  endtask
  task automatic start;
    hold(6);
    sda_drv <= 1'b1;
    hold(6);
    scl <= 1'b1;
    hold(12);
    sda_drv <= 1'b0;
    hold(12);
    scl <= 1'b0;
  endtask
  task automatic stop;
    hold(6);
    sda_drv <= 1'b0;
    hold(6);
    scl <= 1'b1;
    hold(12);
    sda_drv <= 1'b1;
    hold(12);
  endtask
  task automatic send(input logic [7:0] d, output logic ack_n);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], x);
    end
    bit_io(1'b1, ack_n);
  endtask
  task automatic get(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
  endtask
endmodule
`default_nettype wire

// ---- i2c_push_pull_output_port.v ----
// Functional notes
// - read address: acknowledge, capture pins during ack
// - read data comes from pin levels
// - externally forced pin level is reported
// - multibyte read recaptures pins at every ack
// - write address: acknowledge, sample pins during ack
// - acknowledge each written byte, drive outputs
// - each byte sets all outputs at once
// - eighth bit: low write, high read
// - address 101 plus four decoded select bits
// - reset pin aborts transfer, keeps output latch
// - select pins set power-up output group levels
`timescale 1ns/10ps
`default_nettype none
`include "port_expander_map.vh"
module i2c_push_pull_output_port #(
  parameter WIDTH = 8
) (
  // clock and chip reset
  input wire ref_clk,
  input wire nrst,
  // serial bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_q,
  // interface reset pin
  input wire bus_rst_n,
  // address select pins
  input wire addr_sel_low_group,
  input wire addr_sel_high_group,
  // port outputs and their readback
  output reg [WIDTH-1:0] port_out_q,
  input wire [WIDTH-1:0] port_pin_in
);
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  reg [4+WIDTH:0] meta_q;
  reg [4+WIDTH:0] sync_q;
  reg scl_d1_q;
  reg sda_d1_q;
  wire scl_s = sync_q[0];
  wire sda_s = sync_q[1];
  wire rst_s_n = sync_q[2];
  wire sel_lo_s = sync_q[3];
  wire sel_hi_s = sync_q[4];
  wire [WIDTH-1:0] pins_s = sync_q[4+WIDTH:5];
  always @(posedge ref_clk) begin
    if (!nrst) begin
      meta_q <= {(5+WIDTH){1'b1}};
      sync_q <= {(5+WIDTH){1'b1}};
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      meta_q <= {port_pin_in, addr_sel_high_group, addr_sel_low_group, bus_rst_n, sda_in, scl_in};
      sync_q <= meta_q;
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  wire start_cond = scl_s & scl_d1_q & ~sda_s & sda_d1_q;
  wire stop_cond = scl_s & scl_d1_q & sda_s & ~sda_d1_q;

  // ----------------------------------------------------------------
  // select pin wiring detection
  // ----------------------------------------------------------------
  // a pin that tracked scl or sda for the whole transmission so far is
  // taken as wired to that line; otherwise its level decides
  function [1:0] classify;
    input ne_scl;
    input ne_sda;
    input level;
    begin
      if (!ne_scl)
        classify = `WIRE_SCL;
      else if (!ne_sda)
        classify = `WIRE_SDA;
      else if (level)
        classify = `WIRE_VCC;
      else
        classify = `WIRE_GND;
    end
  endfunction
  reg lo_ne_scl_q, lo_ne_sda_q, hi_ne_scl_q, hi_ne_sda_q;
  wire [1:0] lo_wire = classify(lo_ne_scl_q, lo_ne_sda_q, sel_lo_s);
  wire [1:0] hi_wire = classify(hi_ne_scl_q, hi_ne_sda_q, sel_hi_s);
  reg [1:0] lo_code;
  reg [1:0] hi_code;
  always @* begin
    case (lo_wire)
      `WIRE_GND: lo_code = `SEL_LO_GND;
      `WIRE_VCC: lo_code = `SEL_LO_VCC;
      `WIRE_SCL: lo_code = `SEL_LO_SCL;
      default: lo_code = `SEL_LO_SDA;
    endcase
    case (hi_wire)
      `WIRE_GND: hi_code = `SEL_HI_GND;
      `WIRE_VCC: hi_code = `SEL_HI_VCC;
      `WIRE_SCL: hi_code = `SEL_HI_SCL;
      default: hi_code = `SEL_HI_SDA;
    endcase
  end
  wire [6:0] my_addr = {`ADDR_FIXED_HI, hi_code, lo_code};

  // ----------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACK_A = 7'h04;
  localparam [6:0] ST_WDATA = 7'h08;
  localparam [6:0] ST_ACK_W = 7'h10;
  localparam [6:0] ST_RDATA = 7'h20;
  localparam [6:0] ST_RACK = 7'h40;
  reg [6:0] state_q;
  reg [2:0] cnt_q;
  reg [7:0] shift_q;
  reg [WIDTH-1:0] snap_q;
  reg read_q;
  reg mack_q;
  reg [1:0] init_q;
  reg byte_done_q;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      snap_q <= {WIDTH{1'b0}};
      read_q <= 1'b0;
      mack_q <= 1'b0;
      init_q <= 2'h0;
      byte_done_q <= 1'b0;
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
      port_out_q <= {WIDTH{1'b0}};
      lo_ne_scl_q <= 1'b0;
      lo_ne_sda_q <= 1'b0;
      hi_ne_scl_q <= 1'b0;
      hi_ne_sda_q <= 1'b0;
    end else begin
      // power-up levels are taken once synchronised select levels exist;
      // pins tied to the bus lines read high here through the pullups;
      // the chain still shows its reset fill for the first two edges
      if (init_q != 2'h3) begin
        init_q <= init_q + 2'h1;
      end
      if (init_q == `SYNC_SETTLE) begin
        port_out_q <= {{(WIDTH/2){sel_hi_s}}, {(WIDTH/2){sel_lo_s}}};
      end
      if (state_q != ST_IDLE) begin
        lo_ne_scl_q <= lo_ne_scl_q | (sel_lo_s ^ scl_s);
        lo_ne_sda_q <= lo_ne_sda_q | (sel_lo_s ^ sda_s);
        hi_ne_scl_q <= hi_ne_scl_q | (sel_hi_s ^ scl_s);
        hi_ne_sda_q <= hi_ne_sda_q | (sel_hi_s ^ sda_s);
      end
      if (!rst_s_n || stop_cond) begin
        // abort: the output latch is left alone
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        cnt_q <= 3'h0;
        byte_done_q <= 1'b0;
      end else if (start_cond) begin
        state_q <= ST_ADDR;
        sda_oe_q <= 1'b0;
        cnt_q <= 3'h0;
        byte_done_q <= 1'b0;
        lo_ne_scl_q <= 1'b0;
        lo_ne_sda_q <= 1'b0;
        hi_ne_scl_q <= 1'b0;
        hi_ne_sda_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_WDATA: begin
            // bits are counted on rising scl so the fall closing a start
            // condition is not taken as the end of a bit
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 3'h1;
              byte_done_q <= (cnt_q == `LAST_BIT);
            end
            if (scl_fall) begin
              if (byte_done_q) begin
                byte_done_q <= 1'b0;
                if (state_q == ST_WDATA) begin
                  port_out_q <= shift_q[WIDTH-1:0];
                  sda_oe_q <= 1'b1;
                  state_q <= ST_ACK_W;
                end else if (shift_q[7:1] == my_addr) begin
                  read_q <= shift_q[0];
                  sda_oe_q <= 1'b1;
                  state_q <= ST_ACK_A;
                end else begin
                  state_q <= ST_IDLE;
                end
              end
            end
          end
          ST_ACK_A: begin
            if (scl_rise) begin
              snap_q <= pins_s;
            end
            if (scl_fall) begin
              if (read_q) begin
                shift_q <= snap_q;
                sda_oe_q <= ~snap_q[WIDTH-1];
                state_q <= ST_RDATA;
              end else begin
                sda_oe_q <= 1'b0;
                state_q <= ST_WDATA;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (cnt_q == `LAST_BIT) begin
                cnt_q <= 3'h0;
                sda_oe_q <= 1'b0;
                state_q <= ST_RACK;
              end else begin
                cnt_q <= cnt_q + 3'h1;
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe_q <= ~shift_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
              snap_q <= pins_s;
            end
            if (scl_fall) begin
              if (mack_q) begin
                shift_q <= snap_q;
                sda_oe_q <= ~snap_q[WIDTH-1];
                state_q <= ST_RDATA;
              end else begin
                // line stays released until the next start
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- i2c_push_pull_output_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_push_pull_output_port_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic bus_rst_n = 1'b1;
  logic frc_en = 1'b0;
  logic [7:0] frc_v = 8'h00;
  logic [1:0] lo_wiring = 2'h1;
  logic [1:0] hi_wiring = 2'h1;
  logic [7:0] r;
  logic a;
  int err_total = 0;
  int samples_checked = 0;
  wire scl;
  wire sda_drv;
  wire sda_oe_q;
  wire sda_out_q;
  wire [7:0] port_out_q;
  // pins follow the latch unless a load overrides them
  wire [7:0] pins = frc_en ? frc_v : port_out_q;
  wire sda = sda_drv & ~(sda_oe_q & ~sda_out_q);
  // select pin wiring: 0 ground, 1 supply, 2 bus clock, 3 bus data
  wire sel_lo = (lo_wiring == 2'h0) ? 1'b0 : (lo_wiring == 2'h1) ? 1'b1 :
    (lo_wiring == 2'h2) ? scl : sda;
  wire sel_hi = (hi_wiring == 2'h0) ? 1'b0 : (hi_wiring == 2'h1) ? 1'b1 :
    (hi_wiring == 2'h2) ? scl : sda;
  initial forever #5 ref_clk = ~ref_clk;
  i2c_master_model m_u (.ref_clk(ref_clk), .sda_bus(sda), .scl(scl), .sda_drv(sda_drv));
  i2c_push_pull_output_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .bus_rst_n(bus_rst_n),
    .addr_sel_low_group(sel_lo), .addr_sel_high_group(sel_hi), .port_out_q(port_out_q),
    .port_pin_in(pins));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----
  // scenarios, select pins both high (address 5d) except where t_sel rewires them
  // ----
  task automatic t_write;
    m_u.start();
    m_u.send(8'hba, a);
    chk({7'h0, a}, 8'h00);
    m_u.send(8'h3c, a);
    chk({7'h0, a}, 8'h00);
    chk(port_out_q, 8'h3c);
    m_u.send(8'ha5, a);
    chk(port_out_q, 8'ha5);
    m_u.stop();
    m_u.start();
    m_u.send(8'hb0, a);
    chk({7'h0, a}, 8'h01);
    m_u.stop();
    $display("write done");
  endtask
  task automatic t_read;
    frc_v <= 8'h5a;
    frc_en <= 1'b1;
    m_u.start();
    m_u.send(8'hbb, a);
    chk({7'h0, a}, 8'h00);
    m_u.get(r);
    chk(r, 8'h5a);
    frc_v <= 8'hc3;
    m_u.bit_io(1'b0, a);
    m_u.get(r);
    chk(r, 8'hc3);
    m_u.bit_io(1'b1, a);
    m_u.get(r);
    chk(r, 8'hff);
    m_u.stop();
    frc_en <= 1'b0;
    $display("read done");
  endtask
  task automatic t_abort;
    m_u.start();
    m_u.send(8'hba, a);
    for (int i = 0; i < 4; i++) begin
      m_u.bit_io(1'b0, a);
    end
    bus_rst_n <= 1'b0;
    m_u.hold(5);
    bus_rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m_u.bit_io(1'b0, a);
    end
    m_u.bit_io(1'b1, a);
    chk({7'h0, a}, 8'h01);
    chk(port_out_q, 8'ha5);
    m_u.stop();
    frc_v <= 8'h00;
    frc_en <= 1'b1;
    m_u.start();
    m_u.send(8'hbb, a);
    m_u.bit_io(1'b1, a);
    m_u.bit_io(1'b1, a);
    bus_rst_n <= 1'b0;
    m_u.hold(5);
    bus_rst_n <= 1'b1;
    m_u.get(r);
    chk(r, 8'hff);
    m_u.stop();
    frc_en <= 1'b0;
    m_u.start();
    m_u.send(8'hba, a);
    m_u.send(8'h00, a);
    chk(port_out_q, 8'h00);
    m_u.stop();
    $display("abort done");
  endtask
  task automatic t_sel;
    lo_wiring <= 2'h1;
    hi_wiring <= 2'h0;
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(port_out_q, 8'h0f);
    m_u.start();
    m_u.send(8'hb2, a);
    chk({7'h0, a}, 8'h00);
    m_u.stop();
    lo_wiring <= 2'h2;
    hi_wiring <= 2'h3;
    m_u.start();
    m_u.send(8'hac, a);
    chk({7'h0, a}, 8'h00);
    m_u.send(8'h81, a);
    chk(port_out_q, 8'h81);
    m_u.stop();
    $display("select done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(port_out_q, 8'hff);
    t_write();
    t_read();
    t_abort();
    t_sel();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire

// ---- port_bus_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module port_bus_props #(
  parameter WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_q,
  input wire logic bus_rst_n,
  input wire logic [WIDTH-1:0] port_out_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence start_s;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_s;
    scl_in && $rose(sda_in);
  endsequence
  a_oe_rise_low: assert property ($rose(sda_oe_q) |-> !scl_in)
    else $error("sda pulled while scl high");
  a_oe_fall_low: assert property ($fell(sda_oe_q) && $past(bus_rst_n, 3) |-> !scl_in)
    else $error("sda freed while scl high");
  a_oe_held: assert property ($rose(sda_oe_q) |=> sda_oe_q[*8])
    else $error("sda pull too short");
  a_out_scl_low: assert property ($changed(port_out_q) && $past(nrst, 5) |-> !scl_in)
    else $error("outputs moved with scl high");
  a_rst_keeps_out: assert property (!bus_rst_n[*3] |=> $stable(port_out_q))
    else $error("interface reset moved outputs");
  a_rst_frees_sda: assert property (!bus_rst_n[*4] |-> !sda_oe_q)
    else $error("sda held in interface reset");
  a_stop_quiet: assert property (stop_s |=> !sda_oe_q[*6])
    else $error("sda pulled after stop");
  a_start_quiet: assert property (start_s |=> !sda_oe_q[*8])
    else $error("sda pulled after start");
endmodule
bind i2c_push_pull_output_port port_bus_props #(.WIDTH(WIDTH)) props_u (.ref_clk(ref_clk),
  .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_q(sda_oe_q),
  .bus_rst_n(bus_rst_n), .port_out_q(port_out_q));
`default_nettype wire

// ---- port_expander_map.vh ----
`ifndef PORT_EXPANDER_MAP_VH
`define PORT_EXPANDER_MAP_VH
// fixed upper slave address bits
`define ADDR_FIXED_HI 3'h5
// address code per select pin wiring: low group gives bits 1..0
`define SEL_LO_GND 2'h0
`define SEL_LO_VCC 2'h1
`define SEL_LO_SCL 2'h2
`define SEL_LO_SDA 2'h3
// high group gives bits 3..2
`define SEL_HI_SCL 2'h0
`define SEL_HI_SDA 2'h1
`define SEL_HI_GND 2'h2
`define SEL_HI_VCC 2'h3
// bit index of the last bit in a byte
`define LAST_BIT 3'h7
// wiring classes of a select pin
`define WIRE_GND 2'h0
`define WIRE_VCC 2'h1
`define WIRE_SCL 2'h2
`define WIRE_SDA 2'h3
// edges after reset release before the select levels have crossed both flops
`define SYNC_SETTLE 2'h2
`endif

// ---- unused_placeholder_none.v ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire
